// ==== pkg/pmusq_params.svh ====
/*
  Constants of the power sequencer: register offsets, field positions,
  reset values, resource indices and timing counts.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef PMUSQ_PARAMS_SVH
`define PMUSQ_PARAMS_SVH

// Clocking
`define PMUSQ_PCLK_HZ 100000000
`define PMUSQ_LPC_HZ 32768
`define PMUSQ_LPC_DIV (`PMUSQ_PCLK_HZ / `PMUSQ_LPC_HZ)

// Resource count and indices
`define PMUSQ_NRES 8
`define PMUSQ_NCLK 4
`define PMUSQ_R_AON 0
`define PMUSQ_R_BUCK 1
`define PMUSQ_R_CORE_LINEAR_REGULATOR 2
`define PMUSQ_R_LOW_NOISE_LINEAR_REGULATOR 3
`define PMUSQ_R_XTAL 4
`define PMUSQ_R_PLL 5
`define PMUSQ_R_RADIO 6
`define PMUSQ_R_CORE 7

// Register byte offsets
`define PMUSQ_A_CTRL 12'h000
`define PMUSQ_A_MINMASK 12'h004
`define PMUSQ_A_REQTMR 12'h008
`define PMUSQ_A_STATUS 12'h00C
`define PMUSQ_A_CLKMAP 12'h010
`define PMUSQ_A_RESCFG 12'h020
`define PMUSQ_A_LAST 12'h03C

// Field positions
`define PMUSQ_F_DYN_LDO 0
`define PMUSQ_F_RT_MASK 16
`define PMUSQ_F_CFG_ON 8
`define PMUSQ_F_CFG_OFF 16
`define PMUSQ_F_ST_BUSY 8
`define PMUSQ_F_ST_MODE 16
`define PMUSQ_F_ST_REGS 18
`define PMUSQ_F_ST_CAL 19

// Reset values: dependency mask, on delay, off delay
`define PMUSQ_CFG_RST 24'h020201
`define PMUSQ_MIN_RST 8'h00

`endif

// ==== pkg/pmusq_pkg.sv ====
/*
  Types of the power sequencer: power mode enum, APB carrier structs
  and the single packed state of the design.
  Assumes pmusq_params.svh is on the include path.
*/
`include "pmusq_params.svh"

package pmusq_pkg;

  typedef enum logic [1:0] {
    PMUSQ_OFF = 2'h0,
    PMUSQ_ACTIVE = 2'h1,
    PMUSQ_DOZE = 2'h3,
    PMUSQ_DEEP = 2'h2
  } pmusq_mode_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pmusq_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } pmusq_apb_rsp_t;

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
    logic [3:0] s3;
    logic [3:0] pin;
    logic [11:0] div;
    logic cal_done;
    logic [7:0] on;
    logic [7:0] busy;
    logic [7:0][7:0] tmr;
    logic [7:0] minm;
    logic dyn_ldo;
    logic [3:0][7:0] cmap;
    logic [7:0][23:0] cfg;
    logic [15:0] rt_cnt;
    logic [7:0] rt_mask;
    logic wake;
    logic [7:0] res_en;
    pmusq_mode_t mode;
    logic save;
    logic restore;
    logic [31:0] prdata;
  } pmusq_state_t;

endpackage

// ==== design/pmusq_top.sv ====
/*
  Power sequencer with APB register access. Keeps eight resources in
  four states from requests, a dependency table and per-resource timers
  stepped by a low-power tick divided from pclk.
  Assumes an APB master on pclk and asynchronous host enable, wake and
  resume pins.
*/
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`include "pmusq_params.svh"

//
// Functional notes
// - Each resource is enabled, disabled, turning on or turning off.
// - Timer is zero when stable, nonzero while in a transition.
// - Starting a sequence loads the on or off delay into the timer.
// - Nonzero timers decrement once per low-power tick.
// - Timer at zero ends the transition in enabled or disabled.
// - Zero on delay switches a resource on immediately.
// - Zero off delay switches a resource off immediately.
// - Request set joins core clock requests, minimum mask, request timer.
// - Each clock request maps to its set of needed resources.
// - Each tick computes required set with dependencies, compares status.
// - Timer expiry clears busy flag and toggles the on flag together.
// - Turn off only if enabled, unrequested and no dependent powered.
// - Turn on only if disabled, requested and all dependencies enabled.
// - Buck is required while either enable is high; core regulators too unless dynamic LDO is set.
// - All regulators go off only when both enables are low.
// - Host drives section enables; device releases section from reset.
// - Core and low-noise regulators may follow dynamic demand.
// - Doze stops main clocks; low-power tick keeps the sequencer alive.
// - Save state before core power-off; restore after timer/irq/resume wake.
// - Low-power shutdown tristates outputs and disables input buffers.
// - Shutdown exit is a fresh power-up; tick divider recalibrates.
// - WLAN section held in reset while its enable is low.
module pmusq_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire pmusq_pkg::pmusq_apb_req_t apb_req,
  output pmusq_pkg::pmusq_apb_rsp_t apb_rsp,
  input wire logic wlan_section_power_enable,
  input wire logic bt_section_power_enable,
  input wire logic [3:0] core_clk_req,
  input wire logic ext_wake_irq,
  input wire logic host_resume,
  output logic [7:0] resource_enable,
  output logic [7:0] resource_on_flag,
  output logic [7:0] transition_busy_flag,
  output logic wlan_reset_n,
  output logic bt_reset_n,
  output logic main_clk_enable,
  output logic low_power_clock_tick,
  output logic io_tristate,
  output logic input_buf_disable,
  output logic retention_save,
  output logic retention_restore
);

  localparam logic [11:0] DIV_LAST = 12'(`PMUSQ_LPC_DIV - 1);
  localparam logic [7:0] ONE8 = 8'h01;
  pmusq_pkg::pmusq_state_t st_q;
  pmusq_pkg::pmusq_state_t st_d;
  logic regs_on;
  logic [7:0] req_base;
  logic [7:0] req_full;
  logic [7:0] on_mid;
  logic [7:0] busy_mid;
  logic [7:0] dep_powered;
  logic [7:0] dep_i;
  logic acc_wr;
  logic acc_rd;
  logic addr_ok;
  logic [3:0] pin_rise;
  // Section enables OR-ed for the regulator supply
  assign regs_on = st_q.pin[0] | st_q.pin[1];
  // APB answer: zero wait, read data captured in setup
  assign addr_ok = (apb_req.paddr <= `PMUSQ_A_LAST) &&
                   (apb_req.paddr[1:0] == 2'h0);
  assign acc_wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
  assign acc_rd = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;
  assign apb_rsp.pready = apb_req.psel & apb_req.penable;
  assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~addr_ok;
  assign apb_rsp.prdata = st_q.prdata;
  assign resource_enable = st_q.res_en;
  assign resource_on_flag = st_q.on;
  assign transition_busy_flag = st_q.busy;
  assign wlan_reset_n = st_q.pin[0];
  assign bt_reset_n = st_q.pin[1];
  assign main_clk_enable = st_q.res_en[`PMUSQ_R_XTAL];
  assign low_power_clock_tick = st_q.div == 12'h000;
  assign io_tristate = st_q.mode == pmusq_pkg::PMUSQ_OFF;
  assign input_buf_disable = st_q.mode == pmusq_pkg::PMUSQ_OFF;
  assign retention_save = st_q.save;
  assign retention_restore = st_q.restore;
  always_comb
  begin
    st_d = st_q;
    req_base = '0;
    req_full = '0;
    on_mid = st_q.on;
    busy_mid = st_q.busy;
    dep_powered = '0;
    dep_i = '0;
    st_d.save = 1'b0;
    st_d.restore = 1'b0;
    // Pin synchroniser: change accepted once stages two and three agree
    st_d.s1 = {host_resume, ext_wake_irq, bt_section_power_enable,
               wlan_section_power_enable};
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < 4; i++)
    begin
      if (st_q.s2[i] == st_q.s3[i])
      begin
        st_d.pin[i] = st_q.s3[i];
      end
    end
    pin_rise = st_d.pin & ~st_q.pin;

    // Low-power tick divider, restarted at power-up
    if (st_q.div == 12'h000)
    begin
      st_d.div = DIV_LAST;
      st_d.cal_done = 1'b1;
    end
    else
    begin
      st_d.div = st_q.div - 12'h001;
    end

    // Wake sources, set wins over clear
    if (st_q.wake && st_q.on[`PMUSQ_R_CORE] && !st_q.busy[`PMUSQ_R_CORE])
    begin
      st_d.wake = 1'b0;
      st_d.restore = 1'b1;
    end
    if (pin_rise[2] || pin_rise[3])
    begin
      st_d.wake = 1'b1;
    end

    if (st_q.div == 12'h000)
    begin
      // Request timer counts on the tick; expiry is a wake event
      if (st_q.rt_cnt != 16'h0000)
      begin
        st_d.rt_cnt = st_q.rt_cnt - 16'h0001;
        if (st_q.rt_cnt == 16'h0001)
        begin
          st_d.wake = 1'b1;
        end
      end

      // Timers step down; expiry toggles state and drops busy
      for (int i = 0; i < 8; i++)
      begin
        if (st_q.tmr[i] != 8'h00)
        begin
          st_d.tmr[i] = st_q.tmr[i] - 8'h01;
          if (st_q.tmr[i] == 8'h01)
          begin
            busy_mid[i] = 1'b0;
            on_mid[i] = ~st_q.on[i];
          end
        end
      end

      // Required set from all request sources
      for (int c = 0; c < 4; c++)
      begin
        if (core_clk_req[c])
        begin
          req_base = req_base | st_q.cmap[c];
        end
      end
      req_base = req_base | st_q.minm;
      if (st_q.rt_cnt != 16'h0000)
      begin
        req_base = req_base | st_q.rt_mask;
      end
      if (st_q.wake)
      begin
        req_base[`PMUSQ_R_CORE] = 1'b1;
        req_base[`PMUSQ_R_XTAL] = 1'b1;
      end
      req_base[`PMUSQ_R_AON] = 1'b1;
      req_base[`PMUSQ_R_BUCK] = 1'b1;
      if (!st_q.dyn_ldo)
      begin
        req_base[`PMUSQ_R_CORE_LINEAR_REGULATOR] = 1'b1;
        req_base[`PMUSQ_R_LOW_NOISE_LINEAR_REGULATOR] = 1'b1;
      end
      req_full = regs_on ? req_base : 8'h00;

      // Dependency closure over the table
      for (int p = 0; p < 8; p++)
      begin
        for (int i = 0; i < 8; i++)
        begin
          if (req_full[i])
          begin
            req_full = req_full | (st_q.cfg[i][7:0] & ~(ONE8 << i));
          end
        end
      end

      // Resources with a powered dependent
      for (int j = 0; j < 8; j++)
      begin
        if (on_mid[j] || busy_mid[j])
        begin
          dep_powered = dep_powered | (st_q.cfg[j][7:0] & ~(ONE8 << j));
        end
      end

      // Compare with status and start sequences
      for (int i = 0; i < 8; i++)
      begin
        dep_i = st_q.cfg[i][7:0] & ~(ONE8 << i);
        if (on_mid[i] && !busy_mid[i] && !req_full[i] &&
            !dep_powered[i])
        begin
          if (i == `PMUSQ_R_CORE)
          begin
            st_d.save = 1'b1;
          end
          if (st_q.cfg[i][23:16] == 8'h00)
          begin
            on_mid[i] = 1'b0;
          end
          else
          begin
            st_d.tmr[i] = st_q.cfg[i][23:16];
            busy_mid[i] = 1'b1;
          end
        end
        else if (!on_mid[i] && !busy_mid[i] && req_full[i] &&
                 ((dep_i & ~(on_mid & ~busy_mid)) == 8'h00))
        begin
          if (st_q.cfg[i][15:8] == 8'h00)
          begin
            on_mid[i] = 1'b1;
          end
          else
          begin
            st_d.tmr[i] = st_q.cfg[i][15:8];
            busy_mid[i] = 1'b1;
          end
        end
      end
    end
    st_d.on = on_mid;
    st_d.busy = busy_mid;
    st_d.res_en = on_mid ^ busy_mid;
    // Power mode from resource status
    if (!regs_on && on_mid == 8'h00 && busy_mid == 8'h00)
    begin
      st_d.mode = pmusq_pkg::PMUSQ_OFF;
    end
    else if ((on_mid[`PMUSQ_R_XTAL] ^ busy_mid[`PMUSQ_R_XTAL]) ||
             !on_mid[`PMUSQ_R_CORE] && busy_mid[`PMUSQ_R_CORE])
    begin
      st_d.mode = pmusq_pkg::PMUSQ_ACTIVE;
    end
    else if (on_mid[`PMUSQ_R_CORE])
    begin
      st_d.mode = pmusq_pkg::PMUSQ_DOZE;
    end
    else
    begin
      st_d.mode = pmusq_pkg::PMUSQ_DEEP;
    end
    // Register read captured in the setup cycle
    if (acc_rd)
    begin
      st_d.prdata = 32'h0000_0000;
      if (apb_req.paddr == `PMUSQ_A_CTRL)
      begin
        st_d.prdata[`PMUSQ_F_DYN_LDO] = st_q.dyn_ldo;
      end
      else if (apb_req.paddr == `PMUSQ_A_MINMASK)
      begin
        st_d.prdata[7:0] = st_q.minm;
      end
      else if (apb_req.paddr == `PMUSQ_A_REQTMR)
      begin
        st_d.prdata = {8'h00, st_q.rt_mask, st_q.rt_cnt};
      end
      else if (apb_req.paddr == `PMUSQ_A_STATUS)
      begin
        st_d.prdata = {12'h000, st_q.cal_done, regs_on, st_q.mode,
                       st_q.busy, st_q.on};
      end
      else if (apb_req.paddr >= `PMUSQ_A_CLKMAP &&
               apb_req.paddr < `PMUSQ_A_RESCFG)
      begin
        st_d.prdata[7:0] = st_q.cmap[apb_req.paddr[3:2]];
      end
      else if (apb_req.paddr >= `PMUSQ_A_RESCFG &&
               apb_req.paddr <= `PMUSQ_A_LAST)
      begin
        st_d.prdata[23:0] = st_q.cfg[apb_req.paddr[4:2]];
      end
    end

    // Register writes take effect in the access cycle
    if (acc_wr && addr_ok)
    begin
      if (apb_req.paddr == `PMUSQ_A_CTRL)
      begin
        st_d.dyn_ldo = apb_req.pwdata[`PMUSQ_F_DYN_LDO];
      end
      else if (apb_req.paddr == `PMUSQ_A_MINMASK)
      begin
        st_d.minm = apb_req.pwdata[7:0];
      end
      else if (apb_req.paddr == `PMUSQ_A_REQTMR)
      begin
        st_d.rt_cnt = apb_req.pwdata[15:0];
        st_d.rt_mask = apb_req.pwdata[`PMUSQ_F_RT_MASK +: 8];
      end
      else if (apb_req.paddr >= `PMUSQ_A_CLKMAP &&
               apb_req.paddr < `PMUSQ_A_RESCFG)
      begin
        st_d.cmap[apb_req.paddr[3:2]] = apb_req.pwdata[7:0];
      end
      else if (apb_req.paddr >= `PMUSQ_A_RESCFG)
      begin
        st_d.cfg[apb_req.paddr[4:2]] = apb_req.pwdata[23:0];
      end
    end

    // Power-down keeps nothing; next power-up starts from defaults
    if (st_q.mode == pmusq_pkg::PMUSQ_OFF)
    begin
      st_d.minm = `PMUSQ_MIN_RST;
      st_d.dyn_ldo = 1'b0;
      st_d.cmap = '0;
      st_d.cfg = {8{`PMUSQ_CFG_RST}};
      st_d.rt_cnt = 16'h0000;
      st_d.rt_mask = 8'h00;
      st_d.wake = 1'b0;
      st_d.cal_done = 1'b0;
      if (regs_on)
      begin
        st_d.div = DIV_LAST;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= '0;
      st_q.cfg <= {8{`PMUSQ_CFG_RST}};
      st_q.div <= DIV_LAST;
      st_q.minm <= `PMUSQ_MIN_RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end
  // Checks
  timer_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q.busy[`PMUSQ_R_CORE_LINEAR_REGULATOR] == (st_q.tmr[`PMUSQ_R_CORE_LINEAR_REGULATOR] != 8'h00)))
    else $error("Timer and busy flag disagree");
  tick_decrement_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q.div == 12'h000 && st_q.tmr[`PMUSQ_R_BUCK] > 8'h01)
    |=> st_q.tmr[`PMUSQ_R_BUCK] == $past(st_q.tmr[`PMUSQ_R_BUCK]) - 8'h01)
    else $error("Timer did not step by one on tick");
  expiry_toggle_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q.div == 12'h000 && st_q.tmr[`PMUSQ_R_PLL] == 8'h01)
    |=> !st_q.busy[`PMUSQ_R_PLL] && st_q.on[`PMUSQ_R_PLL] !=
        $past(st_q.on[`PMUSQ_R_PLL]) || st_q.busy[`PMUSQ_R_PLL] &&
        st_q.on[`PMUSQ_R_PLL] == $past(st_q.on[`PMUSQ_R_PLL]))
    else $error("Expiry did not finish transition");
  hold_state_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q.busy[`PMUSQ_R_CORE] && st_q.tmr[`PMUSQ_R_CORE] > 8'h01)
    |=> $stable(st_q.on[`PMUSQ_R_CORE]) && st_q.busy[`PMUSQ_R_CORE])
    else $error("Transition interrupted before timer end");
  off_timer_a: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(st_q.busy[`PMUSQ_R_CORE]) && st_q.on[`PMUSQ_R_CORE])
    |-> st_q.tmr[`PMUSQ_R_CORE] == $past(st_q.cfg[`PMUSQ_R_CORE][23:16])
        && retention_save)
    else $error("Core off did not load delay or save state");
  regs_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    (regs_on && st_q.div == 12'h000 && st_q.on[`PMUSQ_R_BUCK] &&
     !st_q.busy[`PMUSQ_R_BUCK]) |=> st_q.on[`PMUSQ_R_BUCK])
    else $error("Buck switched off while an enable is high");
  wlan_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q.s2[0] && st_q.s3[0]) |=> wlan_reset_n)
    else $error("WLAN reset not released after stable enable");
  shutdown_io_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q.mode == pmusq_pkg::PMUSQ_OFF) |-> io_tristate && input_buf_disable
        && !main_clk_enable)
    else $error("Outputs not released in shutdown");
  doze_clock_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q.mode == pmusq_pkg::PMUSQ_DOZE) |-> !main_clk_enable)
    else $error("Main clock running in doze");
endmodule

// ==== test/pmusq_host.sv ====
/*
  Host model: drives the two section enables and the wake and resume
  pins of the power sequencer.
  Assumes a caller that invokes its tasks right after a pclk edge.
*/
`timescale 1ns/100ps
module pmusq_host (
  input wire logic pclk,
  output logic wlan_en,
  output logic bt_en,
  output logic wake,
  output logic resume
);
  initial
  begin
    wlan_en = 1'b0;
    bt_en = 1'b0;
    wake = 1'b0;
    resume = 1'b0;
  end

  // Section enables are levels held until changed
  task automatic set_en(input logic w, input logic b);
    wlan_en <= w;
    bt_en <= b;
    @(posedge pclk);
  endtask

  // Wake or resume pulse, long enough to pass the pin filter
  task automatic pulse(input logic which);
    if (which)
      resume <= 1'b1;
    else
      wake <= 1'b1;
    repeat (10) @(posedge pclk);
    resume <= 1'b0;
    wake <= 1'b0;
    @(posedge pclk);
  endtask
endmodule

// ==== test/pmusq_top_test.sv ====
/*
  Self-checking bench of the power sequencer: APB master, core clock
  requests and a host model for enables and wake pins.
  Assumes the sequencer tick of about 3051 pclk cycles.
*/
`timescale 1ns/100ps
module pmusq_top_test;
  logic pclk;
  logic presetn;
  pmusq_pkg::pmusq_apb_req_t req;
  pmusq_pkg::pmusq_apb_rsp_t rsp;
  logic wlan_en, bt_en, wake, resume;
  logic [3:0] clk_req;
  logic [7:0] res_en, on_f, busy_f;
  logic wl_rst_n, bt_rst_n, mclk_en, tick, io_ts, ibuf_dis, save, restore;
  int fail_count, comparisons, save_seen, restore_seen;
  logic [31:0] rd;
  logic err;

  pmusq_top uut (.pclk(pclk), .presetn(presetn), .apb_req(req),
    .apb_rsp(rsp), .wlan_section_power_enable(wlan_en),
    .bt_section_power_enable(bt_en), .core_clk_req(clk_req),
    .ext_wake_irq(wake), .host_resume(resume), .resource_enable(res_en),
    .resource_on_flag(on_f), .transition_busy_flag(busy_f),
    .wlan_reset_n(wl_rst_n), .bt_reset_n(bt_rst_n),
    .main_clk_enable(mclk_en), .low_power_clock_tick(tick),
    .io_tristate(io_ts), .input_buf_disable(ibuf_dis),
    .retention_save(save), .retention_restore(restore));

  pmusq_host host (.pclk(pclk), .wlan_en(wlan_en), .bt_en(bt_en),
    .wake(wake), .resume(resume));

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    if (save === 1'b1)
      save_seen++;
    if (restore === 1'b1)
      restore_seen++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
    input string what);
    comparisons++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    @(posedge pclk);
    while (rsp.pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    check(n < 20, 1'b1, "apb answer");
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Returns three edges after the n-th tick edge
  task automatic tick_wait(input int n);
    repeat (n) @(posedge pclk iff tick === 1'b1);
    repeat (3) @(posedge pclk);
  endtask

  task automatic s_regs;
    apb(1'b0, 12'h020, 32'h0);
    check(rd, 32'h00020201, "cfg reset");
    apb(1'b0, 12'h040, 32'h0);
    check(err, 1'b1, "unmapped error");
    check(rd, 32'h0, "unmapped read");
    apb(1'b1, 12'h002, 32'hFF);
    check(err, 1'b1, "unaligned");
  endtask

  task automatic s_power_up;
    host.set_en(1'b1, 1'b0);
    repeat (6) @(posedge pclk);
    check({wl_rst_n, bt_rst_n}, 2'h2, "section reset");
    tick_wait(1);
    check({res_en[0], busy_f[1:0], on_f[0]}, 4'hA, "aon start");
    tick_wait(1);
    check({busy_f[1:0], on_f[0]}, 3'h2, "aon timing");
    tick_wait(1);
    check({busy_f[0], on_f[0]}, 2'h1, "aon done");
    tick_wait(3);
    check(on_f, 8'h0F, "regs on");
    check(busy_f, 8'h00, "stable busy");
  endtask

  task automatic s_zero_delay;
    apb(1'b1, 12'h030, 32'h00000001);
    apb(1'b1, 12'h004, 32'h10);
    tick_wait(1);
    check({on_f[4], busy_f[4], mclk_en}, 3'h5, "zero on");
    apb(1'b0, 12'h00C, 32'h0);
    check(rd[15:0], 16'h001F, "status");
    apb(1'b1, 12'h004, 32'h0);
    tick_wait(1);
    check({on_f[4], busy_f[4]}, 2'h0, "zero off");
  endtask

  task automatic s_clock_map;
    apb(1'b1, 12'h010, 32'h20);
    clk_req <= 4'h1;
    tick_wait(1);
    check({busy_f[5], res_en[5], on_f[5]}, 3'h6, "clk start");
    tick_wait(2);
    check({busy_f[5], on_f[5]}, 2'h1, "clk on");
    clk_req <= 4'h0;
    tick_wait(1);
    check({busy_f[5], res_en[5]}, 2'h2, "clk off start");
    tick_wait(2);
    check({busy_f[5], on_f[5]}, 2'h0, "clk off");
  endtask

  task automatic s_wake;
    host.pulse(1'b0);
    tick_wait(4);
    check(on_f[7], 1'b1, "core woken");
    check(restore_seen != 0, 1'b1, "restore");
    host.pulse(1'b1);
  endtask

  task automatic s_power_down;
    host.set_en(1'b0, 1'b1);
    repeat (6) @(posedge pclk);
    check({wl_rst_n, bt_rst_n}, 2'h1, "bt only");
    tick_wait(2);
    check(on_f[1], 1'b1, "buck kept");
    host.set_en(1'b0, 1'b0);
    tick_wait(7);
    check({on_f, busy_f}, 16'h0, "all off");
    check({io_ts, ibuf_dis}, 2'h3, "shutdown io");
    check(save_seen != 0, 1'b1, "save");
    apb(1'b0, 12'h030, 32'h0);
    check(rd, 32'h00020201, "fresh cfg");
    host.set_en(1'b1, 1'b0);
    tick_wait(1);
    check({busy_f[0], io_ts}, 2'h2, "restart");
  endtask

  task automatic close_out;
    $display("Mismatches %0d of %0d comparisons", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    repeat (95000) @(posedge pclk);
    fail_count++;
    close_out();
  end

  initial
  begin
    presetn = 1'b0;
    req = '0;
    clk_req = 4'h0;
    repeat (5) @(posedge pclk);
    check({res_en, wl_rst_n, io_ts}, 10'h001, "in reset");
    presetn <= 1'b1;
    @(posedge pclk);
    s_regs();
    s_power_up();
    s_zero_delay();
    s_clock_map();
    s_wake();
    s_power_down();
    close_out();
  end
endmodule
